// >>> design/acc_ctrl.sv
// Operation
// - Dual-channel: swap bit 4 crosses inputs to channels A and B; single-channel ignores it.
// - Single-channel: select field 1 picks first input, 2 picks second, reset 01.
// - Run control bit 0 resets to 1; low holds calibration logic in reset.
// - Clearing the run enable also resets the digital and link clock dividers.
// - Setting the run enable again restarts calibration with the new settings.
// - Configuration bit 4 enables offset filtering; resets to 0.
// - Configuration bit 3 enables background offset calibration, only with background enabled.
// - Configuration bit 2 enables foreground offset calibration, needs foreground enabled.
// - Configuration bit 1 enables continuous background calibration; resets to 0.
// - Configuration bit 0 resets to 1; at 1 run foreground, at 0 skip it.
// - Status bit 1 shows background stopped; without background, set on foreground end, or on leaving hold when foreground is off too.
// - Status bit 0 goes high when the foreground calibration completes.
// - Pin source field: 0 foreground done, 2 alarm, 3 low, 1 reserved.
// - Trigger source bit 0 picks software bit at 0, hardware input at 1.
// - Software trigger bit resets to 1 and stands in for the hardware trigger.
`timescale 1ns/1ps
`include "acc_regs.svh"

module acc_ctrl
  import acc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_operating_mode_single,
  input wire logic hardware_trigger_input,
  input wire logic cal_foreground_complete,
  input wire logic background_calibration_enable_stopped,
  input wire logic alarm,
  output logic channel_a_uses_second,
  output logic channel_b_uses_second,
  output logic single_uses_second,
  output logic cal_hold,
  output logic divider_reset,
  output logic cal_start,
  output logic foreground_calibration_enable,
  output logic foreground_offset_enable,
  output logic background_calibration_enable,
  output logic background_offset_enable,
  output logic offset_filter_enable,
  output logic calibration_trigger,
  output logic calibration_status_pin,
  output logic irq
);

  function automatic acc_reg_id_t acc_decode(input logic [11:0] addr);
    case (addr)
      `ACC_ADDR_INPUT_SEL: acc_decode = ACC_REG_INPUT_SEL;
      `ACC_ADDR_RUN_CTRL: acc_decode = ACC_REG_RUN_CTRL;
      `ACC_ADDR_CAL_CFG: acc_decode = ACC_REG_CAL_CFG;
      `ACC_ADDR_PROGRESS: acc_decode = ACC_REG_PROGRESS;
      `ACC_ADDR_PIN_SETUP: acc_decode = ACC_REG_PIN_SETUP;
      `ACC_ADDR_SOFT_TRIG: acc_decode = ACC_REG_SOFT_TRIG;
      `ACC_ADDR_IRQ_STATUS: acc_decode = ACC_REG_IRQ_STATUS;
      `ACC_ADDR_IRQ_MASK: acc_decode = ACC_REG_IRQ_MASK;
      default: acc_decode = ACC_REG_NONE;
    endcase
  endfunction

  // Bus channel state.
  logic aw_held_q, aw_held_d;
  logic [11:0] aw_addr_q, aw_addr_d;
  logic w_held_q, w_held_d;
  logic [7:0] w_data_q, w_data_d;
  logic w_lane_q, w_lane_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic wr_fire;
  acc_reg_id_t wr_id;

  // Software registers.
  logic [7:0] input_sel_q, input_sel_d;
  logic [7:0] run_ctrl_q, run_ctrl_d;
  logic [7:0] cal_cfg_q, cal_cfg_d;
  logic [7:0] pin_setup_q, pin_setup_d;
  logic [7:0] soft_trig_q, soft_trig_d;
  logic [7:0] irq_status_q, irq_status_d;
  logic [7:0] irq_mask_q, irq_mask_d;

  // Calibration progress.
  acc_cal_state_t state_q, state_d;
  logic foreground_complete_q, foreground_complete_d;
  logic stopped_q, stopped_d;
  logic alarm_prev_q, alarm_prev_d;
  logic [7:0] events;
  logic run_en;

  // Pin synchroniser and registered outputs.
  logic trig_meta_q, trig_sync_q;
  logic out_a_q, out_a_d;
  logic out_b_q, out_b_d;
  logic out_single_q, out_single_d;
  logic out_hold_q, out_hold_d;
  logic out_divrst_q, out_divrst_d;
  logic out_start_q, out_start_d;
  logic out_fg_q, out_fg_d;
  logic out_fgos_q, out_fgos_d;
  logic out_bg_q, out_bg_d;
  logic out_bgos_q, out_bgos_d;
  logic out_filt_q, out_filt_d;
  logic out_trig_q, out_trig_d;
  logic out_pin_q, out_pin_d;
  logic out_irq_q, out_irq_d;
  acc_pin_src_t pin_src;

  assign run_en = run_ctrl_q[`ACC_RUN_BIT];
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_id = acc_decode(aw_addr_q);
  assign pin_src = acc_pin_src_t'(pin_setup_q[`ACC_PINSRC_LSB +: 2]);

  // Address and data are taken independently and held until both are present.
  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d = w_held_q;
    w_data_d = w_data_q;
    w_lane_d = w_lane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_awvalid && awready_q) begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata[7:0];
      w_lane_d = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (wr_id == ACC_REG_NONE) ? `ACC_RESP_SLVERR : `ACC_RESP_OKAY;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_held_d && !bvalid_d;
    wready_d = !w_held_d && !bvalid_d;
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = `ACC_RESP_OKAY;
      rdata_d = 32'h0000_0000;
      case (acc_decode(s_axi_araddr))
        ACC_REG_INPUT_SEL: rdata_d[7:0] = input_sel_q;
        ACC_REG_RUN_CTRL: rdata_d[7:0] = run_ctrl_q;
        ACC_REG_CAL_CFG: rdata_d[7:0] = cal_cfg_q;
        ACC_REG_PROGRESS: begin
          rdata_d[`ACC_STOPPED_BIT] = stopped_q;
          rdata_d[`ACC_FGDONE_BIT] = foreground_complete_q;
        end
        ACC_REG_PIN_SETUP: rdata_d[7:0] = pin_setup_q;
        ACC_REG_SOFT_TRIG: rdata_d[7:0] = soft_trig_q;
        ACC_REG_IRQ_STATUS: rdata_d[7:0] = irq_status_q;
        ACC_REG_IRQ_MASK: rdata_d[7:0] = irq_mask_q;
        default: rresp_d = `ACC_RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_held_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `ACC_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `ACC_RESP_OKAY;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q <= w_held_d;
      w_data_q <= w_data_d;
      w_lane_q <= w_lane_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // Register writes, calibration sequencing and sticky event flags.
  always_comb begin
    input_sel_d = input_sel_q;
    run_ctrl_d = run_ctrl_q;
    cal_cfg_d = cal_cfg_q;
    pin_setup_d = pin_setup_q;
    soft_trig_d = soft_trig_q;
    irq_mask_d = irq_mask_q;
    irq_status_d = irq_status_q;
    state_d = state_q;
    foreground_complete_d = foreground_complete_q;
    stopped_d = stopped_q;
    alarm_prev_d = alarm;
    events = 8'h00;
    if (wr_fire && w_lane_q) begin
      case (wr_id)
        ACC_REG_INPUT_SEL: input_sel_d = w_data_q;
        ACC_REG_RUN_CTRL: run_ctrl_d = w_data_q;
        // Config written freely.
        // Writing while running is accepted; software keeps it to hold time.
        ACC_REG_CAL_CFG: cal_cfg_d = w_data_q;
        ACC_REG_PIN_SETUP: pin_setup_d = w_data_q;
        ACC_REG_SOFT_TRIG: soft_trig_d = w_data_q;
        ACC_REG_IRQ_MASK: irq_mask_d = w_data_q;
        ACC_REG_IRQ_STATUS: irq_status_d = irq_status_q & ~w_data_q;
        default: irq_mask_d = irq_mask_q;
      endcase
    end
    case (state_q)
      ACC_ST_HOLD: begin
        // Restart on enable.
        // Leaving hold always restarts from the stored values with the current settings.
        if (run_en) begin
          if (cal_cfg_q[`ACC_FG_BIT]) begin
            state_d = ACC_ST_FG;
          end else if (cal_cfg_q[`ACC_BG_BIT]) begin
            state_d = ACC_ST_BG;
          end else begin
            state_d = ACC_ST_DONE;
            stopped_d = 1'b1;
            events[`ACC_EVT_STOPPED_BIT] = 1'b1;
          end
        end
      end
      ACC_ST_FG: begin
        if (cal_foreground_complete) begin
          foreground_complete_d = 1'b1;
          events[`ACC_EVT_FGDONE_BIT] = 1'b1;
          if (cal_cfg_q[`ACC_BG_BIT]) begin
            state_d = ACC_ST_BG;
          end else begin
            state_d = ACC_ST_DONE;
            stopped_d = 1'b1;
            events[`ACC_EVT_STOPPED_BIT] = 1'b1;
          end
        end
      end
      ACC_ST_BG: begin
        stopped_d = background_calibration_enable_stopped;
        events[`ACC_EVT_STOPPED_BIT] = background_calibration_enable_stopped && !stopped_q;
      end
      ACC_ST_DONE: stopped_d = 1'b1;
      default: state_d = ACC_ST_HOLD;
    endcase
    // Hold in reset.
    // Dropping the enable wins over any sequencing and clears progress.
    if (!run_en) begin
      state_d = ACC_ST_HOLD;
      foreground_complete_d = 1'b0;
      stopped_d = 1'b0;
      events[`ACC_EVT_FGDONE_BIT] = 1'b0;
      events[`ACC_EVT_STOPPED_BIT] = 1'b0;
    end
    events[`ACC_EVT_ALARM_BIT] = alarm && !alarm_prev_q;
    // New events are ORed after the clear so that a set in the clearing cycle survives.
    irq_status_d = irq_status_d | events;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      input_sel_q <= `ACC_RST_INPUT_SEL;
      run_ctrl_q <= `ACC_RST_RUN_CTRL;
      cal_cfg_q <= `ACC_RST_CAL_CFG;
      pin_setup_q <= `ACC_RST_PIN_SETUP;
      soft_trig_q <= `ACC_RST_SOFT_TRIG;
      irq_status_q <= `ACC_RST_IRQ;
      irq_mask_q <= `ACC_RST_IRQ;
      state_q <= ACC_ST_HOLD;
      foreground_complete_q <= 1'b0;
      stopped_q <= 1'b0;
      alarm_prev_q <= 1'b0;
    end else begin
      input_sel_q <= input_sel_d;
      run_ctrl_q <= run_ctrl_d;
      cal_cfg_q <= cal_cfg_d;
      pin_setup_q <= pin_setup_d;
      soft_trig_q <= soft_trig_d;
      irq_status_q <= irq_status_d;
      irq_mask_q <= irq_mask_d;
      state_q <= state_d;
      foreground_complete_q <= foreground_complete_d;
      stopped_q <= stopped_d;
      alarm_prev_q <= alarm_prev_d;
    end
  end

  // The hardware trigger arrives on a pin, so it is brought in through two flops.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_meta_q <= 1'b0;
      trig_sync_q <= 1'b0;
    end else begin
      trig_meta_q <= hardware_trigger_input;
      trig_sync_q <= trig_meta_q;
    end
  end

  // Downstream controls, all registered so consumers never see decode glitches.
  always_comb begin
    out_a_d = !link_operating_mode_single && input_sel_q[`ACC_SWAP_BIT];
    out_b_d = !link_operating_mode_single && !input_sel_q[`ACC_SWAP_BIT];
    // Single-channel select.
    // Reserved codes fall back to the first input.
    out_single_d = link_operating_mode_single &&
                   (input_sel_q[`ACC_SINGLE_LSB +: 2] == `ACC_SINGLE_SECOND);
    out_hold_d = !run_en;
    out_divrst_d = !run_en;
    out_start_d = (state_q == ACC_ST_HOLD) && run_en;
    out_fg_d = cal_cfg_q[`ACC_FG_BIT];
    out_fgos_d = cal_cfg_q[`ACC_FGOS_BIT] && cal_cfg_q[`ACC_FG_BIT];
    out_bg_d = cal_cfg_q[`ACC_BG_BIT];
    out_bgos_d = cal_cfg_q[`ACC_BGOS_BIT] && cal_cfg_q[`ACC_BG_BIT];
    out_filt_d = cal_cfg_q[`ACC_OSFILT_BIT];
    if (pin_setup_q[`ACC_HWSEL_BIT]) begin
      out_trig_d = trig_sync_q;
    end else begin
      out_trig_d = soft_trig_q[`ACC_SOFT_BIT];
    end
    case (pin_src)
      ACC_PIN_FGDONE: out_pin_d = foreground_complete_q;
      ACC_PIN_ALARM: out_pin_d = alarm;
      ACC_PIN_LOW: out_pin_d = 1'b0;
      default: out_pin_d = 1'b0;
    endcase
    out_irq_d = |(irq_status_q & irq_mask_q);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
      out_single_q <= 1'b0;
      out_hold_q <= 1'b0;
      out_divrst_q <= 1'b0;
      out_start_q <= 1'b0;
      out_fg_q <= 1'b1;
      out_fgos_q <= 1'b0;
      out_bg_q <= 1'b0;
      out_bgos_q <= 1'b0;
      out_filt_q <= 1'b0;
      out_trig_q <= 1'b1;
      out_pin_q <= 1'b0;
      out_irq_q <= 1'b0;
    end else begin
      out_a_q <= out_a_d;
      out_b_q <= out_b_d;
      out_single_q <= out_single_d;
      out_hold_q <= out_hold_d;
      out_divrst_q <= out_divrst_d;
      out_start_q <= out_start_d;
      out_fg_q <= out_fg_d;
      out_fgos_q <= out_fgos_d;
      out_bg_q <= out_bg_d;
      out_bgos_q <= out_bgos_d;
      out_filt_q <= out_filt_d;
      out_trig_q <= out_trig_d;
      out_pin_q <= out_pin_d;
      out_irq_q <= out_irq_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign channel_a_uses_second = out_a_q;
  assign channel_b_uses_second = out_b_q;
  assign single_uses_second = out_single_q;
  assign cal_hold = out_hold_q;
  assign divider_reset = out_divrst_q;
  assign cal_start = out_start_q;
  assign foreground_calibration_enable = out_fg_q;
  assign foreground_offset_enable = out_fgos_q;
  assign background_calibration_enable = out_bg_q;
  assign background_offset_enable = out_bgos_q;
  assign offset_filter_enable = out_filt_q;
  assign calibration_trigger = out_trig_q;
  assign calibration_status_pin = out_pin_q;
  assign irq = out_irq_q;

endmodule

// >>> design/acc_pkg.sv
package acc_pkg;

  typedef enum logic [3:0] {
    ACC_REG_NONE = 4'h0,
    ACC_REG_INPUT_SEL = 4'h1,
    ACC_REG_RUN_CTRL = 4'h2,
    ACC_REG_CAL_CFG = 4'h3,
    ACC_REG_PROGRESS = 4'h4,
    ACC_REG_PIN_SETUP = 4'h5,
    ACC_REG_SOFT_TRIG = 4'h6,
    ACC_REG_IRQ_STATUS = 4'h7,
    ACC_REG_IRQ_MASK = 4'h8
  } acc_reg_id_t;

  typedef enum logic [1:0] {
    ACC_ST_HOLD = 2'b00,
    ACC_ST_FG = 2'b01,
    ACC_ST_BG = 2'b10,
    ACC_ST_DONE = 2'b11
  } acc_cal_state_t;

  typedef enum logic [1:0] {
    ACC_PIN_FGDONE = 2'b00,
    ACC_PIN_RSVD = 2'b01,
    ACC_PIN_ALARM = 2'b10,
    ACC_PIN_LOW = 2'b11
  } acc_pin_src_t;

endpackage

// >>> design/acc_regs.svh
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// Register indices and their word-aligned byte addresses.
`define ACC_IDX_INPUT_SEL 12'h060
`define ACC_IDX_RUN_CTRL 12'h061
`define ACC_IDX_CAL_CFG 12'h062
`define ACC_IDX_PROGRESS 12'h06a
`define ACC_IDX_PIN_SETUP 12'h06b
`define ACC_IDX_SOFT_TRIG 12'h06c
`define ACC_IDX_IRQ_STATUS 12'h0f0
`define ACC_IDX_IRQ_MASK 12'h0f1
`define ACC_ADDR_INPUT_SEL 12'h180
`define ACC_ADDR_RUN_CTRL 12'h184
`define ACC_ADDR_CAL_CFG 12'h188
`define ACC_ADDR_PROGRESS 12'h1a8
`define ACC_ADDR_PIN_SETUP 12'h1ac
`define ACC_ADDR_SOFT_TRIG 12'h1b0
`define ACC_ADDR_IRQ_STATUS 12'h3c0
`define ACC_ADDR_IRQ_MASK 12'h3c4

// Reset values.
`define ACC_RST_INPUT_SEL 8'h01
`define ACC_RST_RUN_CTRL 8'h01
`define ACC_RST_CAL_CFG 8'h01
`define ACC_RST_PIN_SETUP 8'h00
`define ACC_RST_SOFT_TRIG 8'h01
`define ACC_RST_IRQ 8'h00

// Field positions.
`define ACC_SWAP_BIT 4
`define ACC_SINGLE_LSB 0
`define ACC_RUN_BIT 0
`define ACC_OSFILT_BIT 4
`define ACC_BGOS_BIT 3
`define ACC_FGOS_BIT 2
`define ACC_BG_BIT 1
`define ACC_FG_BIT 0
`define ACC_STOPPED_BIT 1
`define ACC_FGDONE_BIT 0
`define ACC_PINSRC_LSB 1
`define ACC_HWSEL_BIT 0
`define ACC_SOFT_BIT 0
`define ACC_EVT_FGDONE_BIT 0
`define ACC_EVT_STOPPED_BIT 1
`define ACC_EVT_ALARM_BIT 2

// Field codes.
`define ACC_SINGLE_SECOND 2'h2
`define ACC_RESP_OKAY 2'h0
`define ACC_RESP_SLVERR 2'h2

`endif

// >>> testbench/acc_ctrl_props.sv
`timescale 1ns/1ps
module acc_ctrl_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic link_operating_mode_single,
  input wire logic channel_a_uses_second,
  input wire logic channel_b_uses_second,
  input wire logic cal_hold,
  input wire logic divider_reset,
  input wire logic cal_start,
  input wire logic foreground_calibration_enable,
  input wire logic foreground_offset_enable,
  input wire logic background_calibration_enable,
  input wire logic background_offset_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_div_hold;
    cal_hold == divider_reset;
  endproperty
  property p_start_pulse;
    cal_start |=> !cal_start;
  endproperty
  property p_no_start_hold;
    cal_hold |-> !cal_start;
  endproperty
  property p_restart;
    $fell(cal_hold) |-> ##[0:2] cal_start;
  endproperty
  property p_fgos;
    foreground_offset_enable |-> foreground_calibration_enable;
  endproperty
  property p_bgos;
    background_offset_enable |-> background_calibration_enable;
  endproperty
  // The mode input is registered, so the outputs are judged against its value one cycle back.
  property p_dual;
    $past(rst_b) && !$past(link_operating_mode_single) |-> channel_a_uses_second != channel_b_uses_second;
  endproperty
  property p_single;
    $past(rst_b) && $past(link_operating_mode_single) |-> !channel_a_uses_second && !channel_b_uses_second;
  endproperty
  a_div_hold: assert property (p_div_hold)
    else $error("divider reset differs from hold");
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse longer than one cycle");
  a_no_start_hold: assert property (p_no_start_hold)
    else $error("start while held");
  a_restart: assert property (p_restart)
    else $error("no start after hold release");
  a_fgos: assert property (p_fgos)
    else $error("foreground offset without foreground");
  a_bgos: assert property (p_bgos)
    else $error("background offset without background");
  a_dual: assert property (p_dual)
    else $error("dual routing not exactly one crossed");
  a_single: assert property (p_single)
    else $error("dual routing active in single mode");
  c_restart: cover property ($fell(cal_hold));
  c_start: cover property (cal_start);
  c_bgos: cover property (background_offset_enable);
endmodule

bind acc_ctrl acc_ctrl_props u_props (.clk, .rst_b, .link_operating_mode_single, .channel_a_uses_second,
  .channel_b_uses_second, .cal_hold, .divider_reset, .cal_start, .foreground_calibration_enable,
  .foreground_offset_enable, .background_calibration_enable, .background_offset_enable);

// >>> testbench/acc_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "acc_regs.svh"
module acc_ctrl_tb_top
  import acc_pkg::*;
;
  localparam logic [1:0] OK = `ACC_RESP_OKAY;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic link_operating_mode_single = 1'b0, hardware_trigger_input = 1'b0, cal_foreground_complete = 1'b0;
  logic background_calibration_enable_stopped = 1'b0, alarm = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic channel_a_uses_second, channel_b_uses_second, single_uses_second, cal_hold, divider_reset, cal_start;
  logic foreground_calibration_enable, foreground_offset_enable, background_calibration_enable;
  logic background_offset_enable, offset_filter_enable, calibration_trigger, calibration_status_pin, irq;
  int start_count = 0;
  wire [4:0] cfg_out = {offset_filter_enable, background_offset_enable, background_calibration_enable,
    foreground_offset_enable, foreground_calibration_enable};
  int fail_count = 0;
  int total_checks = 0;
  int cycle_count = 0;

  always #10 clk = ~clk;

  acc_ctrl u_dut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_operating_mode_single,
    .hardware_trigger_input, .cal_foreground_complete, .background_calibration_enable_stopped, .alarm, .channel_a_uses_second,
    .channel_b_uses_second, .single_uses_second, .cal_hold, .divider_reset, .cal_start,
    .foreground_calibration_enable, .foreground_offset_enable, .background_calibration_enable,
    .background_offset_enable, .offset_filter_enable, .calibration_trigger, .calibration_status_pin, .irq);

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // The start pulse lasts one cycle, so it is counted here rather than polled by the scenarios.
  always @(posedge clk) begin
    if (cal_start === 1'b1) start_count <= start_count + 1;
    cycle_count <= cycle_count + 1;
    if (cycle_count == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // No limit of its own: only the bench timeout ends a hung transfer.
    forever begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        s_axi_bready <= 1'b0;
        chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, s_axi_bresp});
        break;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        s_axi_rready <= 1'b0;
        chk($sformatf("rdata %h", a), {24'h0, e}, s_axi_rdata);
        chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, s_axi_rresp});
        break;
      end
    end
  endtask

  task automatic fg_pulse();
    @(posedge clk);
    cal_foreground_complete <= 1'b1;
    @(posedge clk);
    cal_foreground_complete <= 1'b0;
    cyc(3);
  endtask

  task automatic t_reset();
    chk("hold", 0, cal_hold);
    chk("div", 0, divider_reset);
    chk("cfg out", 5'h01, cfg_out);
    chk("trig", 1, calibration_trigger);
    rd(`ACC_ADDR_INPUT_SEL, `ACC_RST_INPUT_SEL, OK);
    rd(`ACC_ADDR_RUN_CTRL, `ACC_RST_RUN_CTRL, OK);
    rd(`ACC_ADDR_CAL_CFG, `ACC_RST_CAL_CFG, OK);
    rd(`ACC_ADDR_PIN_SETUP, `ACC_RST_PIN_SETUP, OK);
    rd(`ACC_ADDR_SOFT_TRIG, `ACC_RST_SOFT_TRIG, OK);
    rd(`ACC_ADDR_IRQ_MASK, `ACC_RST_IRQ, OK);
    chk("start at reset", 1, start_count);
    // A write with its byte lane off is answered but changes nothing.
    @(posedge clk);
    s_axi_wstrb <= 4'h0;
    wr(`ACC_ADDR_INPUT_SEL, 8'h12, OK);
    s_axi_wstrb <= 4'h1;
    rd(`ACC_ADDR_INPUT_SEL, `ACC_RST_INPUT_SEL, OK);
    wr(12'h004, 8'h5a, `ACC_RESP_SLVERR);
    rd(12'h004, 8'h00, `ACC_RESP_SLVERR);
  endtask

  task automatic t_inputs();
    wr(`ACC_ADDR_INPUT_SEL, 8'h11, OK);
    cyc(2);
    chk("swap", 2'b10, {channel_a_uses_second, channel_b_uses_second});
    wr(`ACC_ADDR_INPUT_SEL, 8'h01, OK);
    cyc(2);
    chk("no swap", 2'b01, {channel_a_uses_second, channel_b_uses_second});
    @(posedge clk);
    link_operating_mode_single <= 1'b1;
    wr(`ACC_ADDR_INPUT_SEL, 8'h12, OK);
    cyc(2);
    chk("single second", 3'b001, {channel_a_uses_second, channel_b_uses_second, single_uses_second});
    wr(`ACC_ADDR_INPUT_SEL, 8'h01, OK);
    cyc(2);
    chk("single first", 0, single_uses_second);
    @(posedge clk);
    link_operating_mode_single <= 1'b0;
  endtask

  task automatic t_cfg();
    logic [7:0] cv [4] = '{8'h1f, 8'h0c, 8'h12, 8'h01};
    logic [4:0] ev [4] = '{5'h1f, 5'h00, 5'h14, 5'h01};
    wr(`ACC_ADDR_RUN_CTRL, 8'h00, OK);
    cyc(2);
    chk("hold div", 2'b11, {cal_hold, divider_reset});
    for (int i = 0; i < 4; i++) begin
      wr(`ACC_ADDR_CAL_CFG, cv[i], OK);
      cyc(2);
      chk("cfg out", ev[i], cfg_out);
    end
  endtask

  task automatic t_flow();
    int starts_before;
    starts_before = start_count;
    wr(`ACC_ADDR_RUN_CTRL, 8'h01, OK);
    cyc(3);
    chk("restart", starts_before + 1, start_count);
    rd(`ACC_ADDR_PROGRESS, 8'h00, OK);
    fg_pulse();
    rd(`ACC_ADDR_PROGRESS, 8'h03, OK);
    chk("pin fg", 1, calibration_status_pin);
    rd(`ACC_ADDR_IRQ_STATUS, 8'h03, OK);
    wr(`ACC_ADDR_IRQ_MASK, 8'h03, OK);
    cyc(2);
    chk("irq on", 1, irq);
    wr(`ACC_ADDR_IRQ_STATUS, 8'h01, OK);
    cyc(2);
    rd(`ACC_ADDR_IRQ_STATUS, 8'h02, OK);
    wr(`ACC_ADDR_IRQ_MASK, 8'h00, OK);
    cyc(2);
    chk("irq masked", 0, irq);
    wr(`ACC_ADDR_PIN_SETUP, 8'h06, OK);
    cyc(2);
    chk("pin low", 0, calibration_status_pin);
    wr(`ACC_ADDR_PIN_SETUP, 8'h04, OK);
    @(posedge clk);
    alarm <= 1'b1;
    cyc(3);
    chk("pin alarm", 1, calibration_status_pin);
    rd(`ACC_ADDR_IRQ_STATUS, 8'h06, OK);
    wr(`ACC_ADDR_RUN_CTRL, 8'h00, OK);
    cyc(2);
    rd(`ACC_ADDR_PROGRESS, 8'h00, OK);
    wr(`ACC_ADDR_CAL_CFG, 8'h03, OK);
    wr(`ACC_ADDR_RUN_CTRL, 8'h01, OK);
    fg_pulse();
    rd(`ACC_ADDR_PROGRESS, 8'h01, OK);
    @(posedge clk);
    background_calibration_enable_stopped <= 1'b1;
    cyc(3);
    rd(`ACC_ADDR_PROGRESS, 8'h03, OK);
    wr(`ACC_ADDR_RUN_CTRL, 8'h00, OK);
    wr(`ACC_ADDR_CAL_CFG, 8'h00, OK);
    wr(`ACC_ADDR_RUN_CTRL, 8'h01, OK);
    cyc(3);
    rd(`ACC_ADDR_PROGRESS, 8'h02, OK);
  endtask

  task automatic t_trig();
    @(posedge clk);
    hardware_trigger_input <= 1'b1;
    wr(`ACC_ADDR_SOFT_TRIG, 8'h00, OK);
    cyc(5);
    chk("soft trig", 0, calibration_trigger);
    wr(`ACC_ADDR_PIN_SETUP, 8'h01, OK);
    cyc(5);
    chk("hw trig hi", 1, calibration_trigger);
    @(posedge clk);
    hardware_trigger_input <= 1'b0;
    wr(`ACC_ADDR_SOFT_TRIG, 8'h01, OK);
    cyc(5);
    chk("hw trig lo", 0, calibration_trigger);
  endtask

  initial begin
    cyc(3);
    rst_b <= 1'b1;
    cyc(3);
    t_reset();
    t_inputs();
    t_cfg();
    t_flow();
    t_trig();
    give_verdict();
  end
endmodule
